// ==== rtl/gamma_bus_ctrl.sv ====
// Purpose: APB-programmed serial master that writes and reads the code store
// Assumes: 50 MHz clock
// Notes: one frame per command; data window holds fourteen codes
`timescale 1ns/1ps
`include "gamma_cfg.svh"
module gamma_bus_ctrl
  import gamma_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        resetn,
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  gamma_link_if.controller link
);
  import gamma_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [6:0]  addr_q;
  logic [7:0]  ctrl_q;
  code_t       data_q [`CODE_COUNT];
  master_state_t state_q;
  logic [7:0]  halfCnt_q;
  logic        sclLow_q;
  logic        sdaLow_q;
  logic [3:0]  bitCnt_q;
  logic [4:0]  byteIdx_q;
  logic [7:0]  shift_q;
  logic        dir_q;
  logic        nack_q;
  logic        phase_q;
  logic        sdaS;

  line_sync uSda (.clk(clk), .resetn(resetn), .pinIn(link.sdaLine), .level(sdaS));

  wire apbWr     = psel && penable && pwrite;
  wire busy      = state_q != MS_IDLE;
  wire inData    = paddr >= `DATA_REG_OFS && paddr < `DATA_REG_OFS + 12'h038 && paddr[1:0] == 2'b00;
  wire [3:0] dIx = 4'(paddr[5:2] - 4'h0);
  wire tick      = halfCnt_q == 8'(`SCL_HALF_CYC - 1);
  wire [4:0] lastByte = dir_q ? 5'd`CODE_COUNT : 5'd15;
  // byte that follows the one whose acknowledge is in progress
  wire [7:0] nextTx = byteIdx_q == 5'd0 ? ctrl_q : data_q[4'(byteIdx_q - 5'd1)];

  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = paddr == `ADDR_REG_OFS ? {25'h0, addr_q} :
                   paddr == `CTRL_REG_OFS ? {24'h0, ctrl_q} :
                   paddr == `STAT_REG_OFS ? {30'h0, nack_q, busy} :
                   inData ? {24'h0, data_q[dIx]} : 32'h0;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_q <= `ADDR_BASE_LOW;
      ctrl_q <= 8'h00;
      state_q <= MS_IDLE;
      halfCnt_q <= 8'h00;
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
      bitCnt_q <= 4'h0;
      byteIdx_q <= 5'h00;
      shift_q <= 8'h00;
      dir_q <= 1'b0;
      nack_q <= 1'b0;
      phase_q <= 1'b0;
    end
    else
    begin
      halfCnt_q <= (busy && !tick) ? halfCnt_q + 8'h01 : 8'h00;
      if (apbWr && !busy && paddr == `ADDR_REG_OFS)
        addr_q <= pwdata[6:0];
      if (apbWr && !busy && inData)
        data_q[dIx] <= pwdata[7:0];
      if (apbWr && !busy && paddr == `CTRL_REG_OFS)
      begin
        ctrl_q <= pwdata[7:0];
        if (pwdata[8 + `CMD_START])
        begin
          dir_q <= pwdata[8 + `CMD_DIR];
          nack_q <= 1'b0;
          state_q <= MS_START;
          phase_q <= 1'b0;
        end
      end
      if (tick)
      begin
        case (state_q)
          MS_START:
          begin
            sdaLow_q <= 1'b1;
            byteIdx_q <= 5'd0;
            shift_q <= {addr_q, dir_q};
            bitCnt_q <= 4'h0;
            phase_q <= 1'b1;
            state_q <= MS_BIT;
          end
          MS_BIT:
          begin
            phase_q <= !phase_q;
            if (phase_q)
            begin
              sclLow_q <= 1'b1;
              if (bitCnt_q == 4'd`BYTE_BITS)
              begin
                bitCnt_q <= 4'h0;
                // ack slot: release unless acknowledging a read byte other than the last
                sdaLow_q <= dir_q && byteIdx_q != 5'd0 && byteIdx_q != lastByte;
                state_q <= MS_ACK;
              end
              else
              begin
                sdaLow_q <= !(dir_q && byteIdx_q != 5'd0) && !shift_q[7];
                shift_q <= {shift_q[6:0], 1'b0};
              end
            end
            else
            begin
              sclLow_q <= 1'b0;
              bitCnt_q <= bitCnt_q + 4'h1;
              if (dir_q && byteIdx_q != 5'd0)
                data_q[4'(byteIdx_q - 5'd1)] <= {data_q[4'(byteIdx_q - 5'd1)][6:0], sdaS};
            end
          end
          MS_ACK:
          begin
            phase_q <= !phase_q;
            // ninth pulse: rise first, then judge the acknowledge as it falls
            if (!phase_q)
              sclLow_q <= 1'b0;
            else
            begin
              sclLow_q <= 1'b1;
              if ((!dir_q || byteIdx_q == 5'd0) && sdaS)
                nack_q <= 1'b1;
              if (byteIdx_q == lastByte || ((!dir_q || byteIdx_q == 5'd0) && sdaS))
              begin
                sdaLow_q <= 1'b1;
                state_q <= MS_STOP;
              end
              else
              begin
                byteIdx_q <= byteIdx_q + 5'd1;
                sdaLow_q <= !dir_q && !nextTx[7];
                shift_q <= {nextTx[6:0], 1'b0};
                bitCnt_q <= 4'h0;
                state_q <= MS_BIT;
              end
            end
          end
          MS_STOP:
          begin
            phase_q <= !phase_q;
            if (phase_q)
              sclLow_q <= 1'b0;
            else if (!sclLow_q)
            begin
              sdaLow_q <= 1'b0;
              state_q <= MS_DONE;
            end
          end
          MS_DONE:
            state_q <= MS_IDLE;
          default:
            state_q <= MS_IDLE;
        endcase
      end
    end
  end

  assign link.sclOut       = 1'b0;
  assign link.sclOe        = sclLow_q;
  assign link.sdaMasterOut = 1'b0;
  assign link.sdaMasterOe  = sdaLow_q;
endmodule : gamma_bus_ctrl

// ==== rtl/gamma_cfg.svh ====
// Purpose: constants shared by both ends of the reference-code serial link
// Assumes: 50 MHz system clock
// Notes: timing counts derive from the figures in their own units
`ifndef GAMMA_CFG_SVH
`define GAMMA_CFG_SVH
`define ADDR_UPPER        6'h3A
`define ADDR_BASE_LOW     7'h74
`define ADDR_BASE_HIGH    7'h75
`define CODE_COUNT        14
`define UPPER_COUNT       7
`define CODE_WIDTH        8
`define BYTE_BITS         8
`define CTRL_WRITE_SET    1
`define CTRL_READ_SET     2
`define CTRL_OSC_SRC      3
`define CLK_PERIOD_NS     20
`define SCL_MAX_KHZ       400
// half period of the generated serial clock, rounded up so the rate never exceeds the limit
`define SCL_HALF_NS       1250
`define SCL_HALF_CYC      ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_REG_OFS      12'h000
`define CTRL_REG_OFS      12'h004
`define STAT_REG_OFS      12'h008
`define DATA_REG_OFS      12'h040
`define CMD_START         0
`define CMD_DIR           1
`endif

// ==== rtl/gamma_code_store.sv ====
// Purpose: serial slave holding two sets of fourteen reference codes
// Assumes: controller keeps the serial clock at or below 400 kHz
// Notes: register mode framing is not built; the device stays silent in it
`timescale 1ns/1ps
`include "gamma_cfg.svh"
module gamma_code_store
  import gamma_pkg::*;
(
  // system
  input  wire logic   clk,
  input  wire logic   resetn,
  // link
  gamma_link_if.device link,
  // pins
  input  wire logic   framing_mode_select,
  input  wire logic   address_lsb_pin,
  input  wire logic   curveSelect,
  // codes to the converters
  output gamma_pkg::code_t upper_range_outputs [`UPPER_COUNT],
  output gamma_pkg::code_t lower_range_outputs [`UPPER_COUNT],
  output logic        oscillator_source_bit,
  output logic        busBusy
);
  import gamma_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic sclS;
  logic sdaS;
  logic modeS;
  logic lsbS;
  logic curveS;
  logic sclPrev_q;
  logic sdaPrev_q;
  line_sync uScl (.clk(clk), .resetn(resetn), .pinIn(link.sclLine), .level(sclS));
  line_sync uSda (.clk(clk), .resetn(resetn), .pinIn(link.sdaLine), .level(sdaS));
  line_sync uMode (.clk(clk), .resetn(resetn), .pinIn(framing_mode_select), .level(modeS));
  line_sync uLsb (.clk(clk), .resetn(resetn), .pinIn(address_lsb_pin), .level(lsbS));
  line_sync uCurve (.clk(clk), .resetn(resetn), .pinIn(curveSelect), .level(curveS));

  wire sclRise  = sclS && !sclPrev_q;
  wire sclFall  = !sclS && sclPrev_q;
  wire startSeen = sclS && sclPrev_q && sdaPrev_q && !sdaS;
  wire stopSeen  = sclS && sclPrev_q && !sdaPrev_q && sdaS;
  wire [6:0] ownAddr = {`ADDR_UPPER, lsbS};

  ////////////////////////////////////////////////////////////////////////////
  // two code sets, fourteen codes each
  code_t setA_q [`CODE_COUNT];
  code_t setB_q [`CODE_COUNT];
  slave_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [4:0] byteIdx_q;
  logic       readDir_q;
  logic       writeSet_q;
  logic       readSet_q;
  logic       osc_q;
  logic       sdaLow_q;
  logic       busy_q;
  logic       ackOk_q;

  wire       dataPhase = byteIdx_q >= 5'd1;
  wire [4:0] codeIdx   = byteIdx_q - 5'd1;
  wire [4:0] nextIdx   = readDir_q ? byteIdx_q : byteIdx_q - 5'd1;
  wire code_t readCode = readSet_q ? setB_q[nextIdx[3:0]] : setA_q[nextIdx[3:0]];

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclPrev_q  <= 1'b1;
      sdaPrev_q  <= 1'b1;
      state_q    <= SL_IDLE;
      bitCnt_q   <= 4'h0;
      shift_q    <= 8'h00;
      byteIdx_q  <= 5'h00;
      readDir_q  <= 1'b0;
      writeSet_q <= 1'b0;
      readSet_q  <= 1'b0;
      osc_q      <= 1'b0;
      sdaLow_q   <= 1'b0;
      busy_q     <= 1'b0;
      ackOk_q    <= 1'b0;
    end
    else
    begin
      sclPrev_q <= sclS;
      sdaPrev_q <= sdaS;
      if (startSeen)
        busy_q <= 1'b1;
      else if (stopSeen)
        busy_q <= 1'b0;
      if (startSeen)
      begin
        state_q  <= modeS ? SL_ADDR : SL_SKIP;
        bitCnt_q <= 4'h0;
        sdaLow_q <= 1'b0;
        readDir_q <= 1'b0;
      end
      else if (stopSeen)
      begin
        state_q  <= SL_IDLE;
        sdaLow_q <= 1'b0;
      end
      else
      begin
        case (state_q)
          SL_ADDR, SL_RECV:
          begin
            if (sclRise)
            begin
              shift_q  <= {shift_q[6:0], sdaS};
              bitCnt_q <= bitCnt_q + 4'h1;
            end
            else if (sclFall && bitCnt_q == 4'd`BYTE_BITS)
            begin
              bitCnt_q <= 4'h0;
              if (state_q == SL_ADDR)
              begin
                if (shift_q[7:1] == ownAddr)
                begin
                  readDir_q <= shift_q[0];
                  byteIdx_q <= 5'd0;
                  sdaLow_q  <= 1'b1;
                  state_q   <= SL_ACK;
                end
                else
                  state_q <= SL_SKIP;
              end
              else
              begin
                if (!dataPhase)
                begin
                  writeSet_q <= shift_q[`CTRL_WRITE_SET];
                  readSet_q  <= shift_q[`CTRL_READ_SET];
                  osc_q      <= shift_q[`CTRL_OSC_SRC];
                end
                else if (codeIdx < 5'd`CODE_COUNT)
                begin
                  if (writeSet_q)
                    setB_q[codeIdx[3:0]] <= shift_q;
                  else
                    setA_q[codeIdx[3:0]] <= shift_q;
                end
                byteIdx_q <= byteIdx_q + 5'd1;
                sdaLow_q  <= 1'b1;
                state_q   <= SL_ACK;
              end
            end
          end
          SL_ACK:
          begin
            // leave the acknowledge at the falling edge that closes the ninth pulse
            if (sclFall)
            begin
              if (readDir_q)
              begin
                shift_q  <= {readCode[6:0], 1'b0};
                sdaLow_q <= !readCode[7];
                byteIdx_q <= 5'd1;
                bitCnt_q <= 4'h1;
                state_q  <= SL_SEND;
              end
              else
              begin
                sdaLow_q <= 1'b0;
                state_q  <= SL_RECV;
              end
            end
          end
          SL_SEND:
          begin
            if (sclFall)
            begin
              if (bitCnt_q == 4'd`BYTE_BITS)
              begin
                sdaLow_q <= 1'b0;
                bitCnt_q <= 4'h0;
                state_q  <= SL_SKIP;
                ackOk_q  <= 1'b0;
              end
              else
              begin
                sdaLow_q <= !shift_q[7];
                shift_q  <= {shift_q[6:0], 1'b0};
                bitCnt_q <= bitCnt_q + 4'h1;
              end
            end
          end
          SL_SKIP:
          begin
            // also waits out the master acknowledge of a read byte
            if (readDir_q && bitCnt_q == 4'h0 && sclRise)
            begin
              ackOk_q  <= !sdaS;
              bitCnt_q <= 4'h1;
            end
            else if (readDir_q && bitCnt_q == 4'h1 && sclFall && ackOk_q)
            begin
              byteIdx_q <= byteIdx_q + 5'd1;
              shift_q   <= {readCode[6:0], 1'b0};
              sdaLow_q  <= !readCode[7];
              state_q   <= SL_SEND;
            end
            else if (readDir_q && bitCnt_q == 4'h1 && sclFall)
              readDir_q <= 1'b0;
          end
          default:
            state_q <= SL_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs follow the synchronised curve pin; a read past the fourteenth code is not supported
  genvar gi;
  generate
    for (gi = 0; gi < `UPPER_COUNT; gi = gi + 1)
    begin : gOut
      assign upper_range_outputs[gi] = curveS ? setB_q[gi] : setA_q[gi];
      assign lower_range_outputs[gi] = curveS ? setB_q[gi + `UPPER_COUNT] : setA_q[gi + `UPPER_COUNT];
    end
  endgenerate

  assign link.sdaSlaveOut   = 1'b0;
  assign link.sdaSlaveOe    = sdaLow_q;
  assign oscillator_source_bit = osc_q;
  assign busBusy            = busy_q;
endmodule : gamma_code_store

// ==== rtl/gamma_link_if.sv ====
// Purpose: two-wire link between the bus controller and the code store
// Assumes: open-drain lines with pull-ups
// Notes: wire levels are resolved here from the enables
`timescale 1ns/1ps
interface gamma_link_if;
  logic sclOut;
  logic sclOe;
  logic sdaMasterOut;
  logic sdaMasterOe;
  logic sdaSlaveOut;
  logic sdaSlaveOe;
  logic sclLine;
  logic sdaLine;
  // open drain: any enabled low driver wins, else pulled high
  assign sclLine = !(sclOe && !sclOut);
  assign sdaLine = !((sdaMasterOe && !sdaMasterOut) || (sdaSlaveOe && !sdaSlaveOut));
  modport controller (output sclOut, sclOe, sdaMasterOut, sdaMasterOe, input sclLine, sdaLine);
  modport device (output sdaSlaveOut, sdaSlaveOe, input sclLine, sdaLine);
endinterface : gamma_link_if

// ==== rtl/gamma_pkg.sv ====
// Purpose: types shared by both ends of the reference-code serial link
// Assumes: constants come from gamma_cfg.svh
// Notes: none
package gamma_pkg;
  typedef logic [7:0] code_t;
  typedef enum logic [2:0]
  {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_RECV = 3'b010,
    SL_SEND = 3'b011,
    SL_ACK  = 3'b100,
    SL_SKIP = 3'b101
  } slave_state_t;
  typedef enum logic [2:0]
  {
    MS_IDLE  = 3'b000,
    MS_START = 3'b001,
    MS_BIT   = 3'b010,
    MS_ACK   = 3'b011,
    MS_STOP  = 3'b100,
    MS_DONE  = 3'b101
  } master_state_t;
endpackage : gamma_pkg

// ==== rtl/line_sync.sv ====
// Purpose: three-stage synchroniser with agreement filter for one pin
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second
`timescale 1ns/1ps
module line_sync
(
  // system
  input  wire logic clk,
  input  wire logic resetn,
  // pin
  input  wire logic pinIn,
  output logic      level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q    <= 1'b1;
      s2_q    <= 1'b1;
      s3_q    <= 1'b1;
      level_q <= 1'b1;
    end
    else
    begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end
  assign level = level_q;
endmodule : line_sync

// ==== verification/gamma_dac_i2c_slave_tb_top.sv ====
// Purpose: bench joining the bus controller and the code store across the link
// Assumes: zero-wait APB slave; frames run at the controller's own serial rate
// Notes: every scenario judges its own results
`timescale 1ns/1ps
`include "gamma_cfg.svh"
module gamma_dac_i2c_slave_tb_top;
  import gamma_pkg::*;
  logic        clk = 1'b0;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        modeSel;
  logic        addrPin;
  logic        curveSel;
  code_t       upperOut [`UPPER_COUNT];
  code_t       lowerOut [`UPPER_COUNT];
  logic        oscSrc;
  logic        busBusy;
  logic [31:0] rdata;
  int          err_count = 0;
  int          checks = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  gamma_link_if gamma_link_if_i ();
  gamma_bus_ctrl gamma_bus_ctrl_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(gamma_link_if_i));
  gamma_code_store gamma_code_store_i (.clk(clk), .resetn(resetn), .link(gamma_link_if_i),
    .framing_mode_select(modeSel), .address_lsb_pin(addrPin), .curveSelect(curveSel),
    .upper_range_outputs(upperOut), .lower_range_outputs(lowerOut), .oscillator_source_bit(oscSrc),
    .busBusy(busBusy));
  gamma_link_props gamma_link_props_i (.clk(clk), .resetn(resetn), .sclOut(gamma_link_if_i.sclOut),
    .sclOe(gamma_link_if_i.sclOe), .sdaMasterOut(gamma_link_if_i.sdaMasterOut),
    .sdaMasterOe(gamma_link_if_i.sdaMasterOe), .sdaSlaveOut(gamma_link_if_i.sdaSlaveOut),
    .sdaSlaveOe(gamma_link_if_i.sdaSlaveOe), .sclLine(gamma_link_if_i.sclLine), .sdaLine(gamma_link_if_i.sdaLine));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  // entered right after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdata = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic code_t patt(input int s, input int i);
    return (s != 0 ? 8'hA5 : 8'h3C) + 8'(i * 19);
  endfunction : patt
  task automatic load(input int s);
    for (int i = 0; i < `CODE_COUNT; i++)
      apb(1'b1, `DATA_REG_OFS + 12'(i * 4), {24'h000000, patt(s, i)});
  endtask : load
  // start one frame and wait for the controller to report idle
  task automatic frame(input logic rd, input code_t cb, input logic [1:0] expStat);
    apb(1'b1, `CTRL_REG_OFS, {22'h000000, rd, 1'b1, cb});
    repeat (300) @(posedge clk);
    chk(busBusy, 1'b1, "bus not busy inside frame");
    do
      apb(1'b0, `STAT_REG_OFS, 32'h00000000);
    while (rdata[0] !== 1'b0);
    chk(rdata[1:0], expStat, "frame status");
    repeat (20) @(posedge clk);
    chk(busBusy, 1'b0, "bus still busy after stop");
  endtask : frame
  task automatic show_set(input int s);
    curveSel <= (s != 0);
    repeat (6) @(posedge clk);
    for (int i = 0; i < `UPPER_COUNT; i++)
    begin
      chk(upperOut[i], patt(s, i), "upper range code");
      chk(lowerOut[i], patt(s, i + `UPPER_COUNT), "lower range code");
    end
  endtask : show_set
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(1'b0, `ADDR_REG_OFS, 32'h00000000);
    chk(rdata[6:0], 7'h74, "address reset value");
    apb(1'b0, `STAT_REG_OFS, 32'h00000000);
    chk(rdata[1:0], 2'b00, "status reset value");
    apb(1'b0, 12'hFFC, 32'h00000000);
    chk(rdata, 32'h00000000, "unmapped read");
    chk(pslverr, 1'b0, "slave error raised");
    chk(busBusy, 1'b0, "busy after reset");
    $display("test regs done");
  endtask : t_regs
  task automatic t_write();
    load(0);
    frame(1'b0, 8'h00, 2'b00);
    chk(oscSrc, 1'b0, "oscillator source clear");
    load(1);
    frame(1'b0, 8'hFE, 2'b00);
    chk(oscSrc, 1'b1, "oscillator source set");
    show_set(0);
    show_set(1);
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    for (int i = 0; i < `CODE_COUNT; i++)
      apb(1'b1, `DATA_REG_OFS + 12'(i * 4), 32'h00000000);
    frame(1'b1, 8'h00, 2'b00);
    for (int i = 0; i < `CODE_COUNT; i++)
    begin
      apb(1'b0, `DATA_REG_OFS + 12'(i * 4), 32'h00000000);
      chk(rdata[7:0], patt(1, i), "read back code");
    end
    $display("test read done");
  endtask : t_read
  task automatic t_addr();
    apb(1'b1, `ADDR_REG_OFS, 32'h00000075);
    frame(1'b0, 8'h00, 2'b10);
    show_set(0);
    addrPin <= 1'b1;
    repeat (6) @(posedge clk);
    frame(1'b1, 8'h00, 2'b00);
    apb(1'b0, `DATA_REG_OFS, 32'h00000000);
    chk(rdata[7:0], patt(1, 0), "read at high address");
    $display("test address done");
  endtask : t_addr
  task automatic t_mode();
    modeSel <= 1'b0;
    addrPin <= 1'b0;
    apb(1'b1, `ADDR_REG_OFS, 32'h00000074);
    frame(1'b0, 8'h00, 2'b10);
    modeSel <= 1'b1;
    $display("test mode done");
  endtask : t_mode
  ////////////////////////////////////////////////////////////////////////////
  // ceiling above four full frames of about 18000 cycles at most plus two frames refused at the address
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      err_count++;
      $display("MISMATCH %0t run timed out", $time);
      complete_run();
    end
  end
  initial
  begin
    resetn   = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h00000000;
    modeSel  = 1'b1;
    addrPin  = 1'b0;
    curveSel = 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_write();
    t_read();
    t_addr();
    t_mode();
    complete_run();
  end
endmodule : gamma_dac_i2c_slave_tb_top

// ==== verification/gamma_link_props.sv ====
// Purpose: wire-level checks on the two-wire link between controller and code store
// Assumes: one clock domain; lines already resolved by the interface
// Notes: acknowledge pulses are found by counting serial clock rises since start
`timescale 1ns/1ps
module gamma_link_props
(
  // system
  input wire logic clk,
  input wire logic resetn,
  // link
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic sdaMasterOut,
  input wire logic sdaMasterOe,
  input wire logic sdaSlaveOut,
  input wire logic sdaSlaveOe,
  input wire logic sclLine,
  input wire logic sdaLine
);
  logic       sclPrev_q;
  logic       sdaPrev_q;
  logic [3:0] bitCnt_q;
  logic [4:0] byteCnt_q;
  logic [7:0] shift_q;
  logic       dirRead_q;
  logic       addrHit_q;
  logic [7:0] period_q;
  logic       seenRise_q;
  wire        sclRise   = sclLine & ~sclPrev_q;
  wire        startCond = sclLine & sclPrev_q & sdaPrev_q & ~sdaLine;
  wire        stopCond  = sclLine & sclPrev_q & ~sdaPrev_q & sdaLine;
  wire        ackRise   = sclRise & (bitCnt_q == 4'h8);
  wire        masterLow = sdaMasterOe & ~sdaMasterOut;
  wire        byteZero  = (byteCnt_q == 5'h00);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      sclPrev_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end
    else
    begin
      sclPrev_q <= sclLine;
      sdaPrev_q <= sdaLine;
    end
  // bit position within the current byte, reset by every start
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      bitCnt_q  <= 4'h0;
      byteCnt_q <= 5'h00;
    end
    else if (startCond)
    begin
      bitCnt_q  <= 4'h0;
      byteCnt_q <= 5'h00;
    end
    else if (ackRise)
    begin
      bitCnt_q  <= 4'h0;
      byteCnt_q <= byteCnt_q + 5'h01;
    end
    else if (sclRise)
      bitCnt_q <= bitCnt_q + 4'h1;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      shift_q   <= 8'h00;
      dirRead_q <= 1'b0;
      addrHit_q <= 1'b0;
    end
    else
    begin
      if (sclRise && !ackRise)
        shift_q <= {shift_q[6:0], sdaLine};
      if (sclRise && bitCnt_q == 4'h7 && byteZero)
        dirRead_q <= sdaLine;
      if (startCond)
        addrHit_q <= 1'b0;
      else if (ackRise && byteZero)
        addrHit_q <= sdaSlaveOe;
    end
  // saturating count of cycles since the last serial clock rise
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      period_q   <= 8'h00;
      seenRise_q <= 1'b0;
    end
    else if (sclRise)
    begin
      period_q   <= 8'h00;
      seenRise_q <= 1'b1;
    end
    else if (period_q != 8'hFF)
      period_q <= period_q + 8'h01;
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_stop;
    stopCond;
  endsequence
  sequence s_read_nak;
    ackRise && !byteZero && dirRead_q && sdaLine;
  endsequence
  sequence s_addr_ack;
    ackRise && byteZero && sdaSlaveOe;
  endsequence
  // 400 kHz at 50 MHz is 125 cycles between rises
  a_scl_rate: assert property (sclRise && seenRise_q |-> period_q >= 8'h7C)
    else $error("serial clock period too short");
  a_slave_edge_low: assert property ($changed(sdaSlaveOe) |-> !sclLine)
    else $error("device data changed while clock high");
  a_no_dev_cond: assert property (sclLine && $past(sclLine) && sdaLine != $past(sdaLine) |-> !$past(sdaSlaveOe))
    else $error("device made a start or stop");
  a_idle_stop: assert property (s_stop |=> (sclLine && sdaLine) [*8])
    else $error("lines not idle high after stop");
  a_master_ack_rel: assert property (ackRise && (byteZero || !dirRead_q) |-> !masterLow)
    else $error("master held data low in write acknowledge");
  a_write_ack: assert property (ackRise && !byteZero && !dirRead_q && addrHit_q |-> !sdaLine)
    else $error("device did not acknowledge written byte");
  a_read_release: assert property (ackRise && !byteZero && dirRead_q |-> !sdaSlaveOe)
    else $error("device drove data in read acknowledge");
  a_nak_quiet: assert property (s_read_nak |=> !sdaSlaveOe [*8])
    else $error("device drove data after not-acknowledge");
  a_addr_match: assert property (s_addr_ack |-> shift_q[7:2] == 6'h3A)
    else $error("device acknowledged a foreign address");
endmodule : gamma_link_props
